/* rtl/boot_pin_cfg.svh */
// Purpose: Constants for the boot pin drive sequencer.
// Assumes: Durations are counted in sleep-clock cycles, seen as a synchronous strobe.
// Notes: Drive modes are encoded in boot_pin_pkg.
// Contract
// - At power-up drive the data pin strong high for 256 sleep cycles first.
// - Then drive the data pin resistive low for another 256 sleep cycles.
// - At power-up drive the clock pin resistive low for 512 sleep cycles, concurrently.
// - After the power-up intervals both pins go to high impedance.
// - After external reset falls, drive both pins resistive low 8 cycles, then release.
// - External reset is active high, pulled low inside; high holds the device in reset.
`ifndef BOOT_PIN_CFG_SVH
`define BOOT_PIN_CFG_SVH

`define PWR_HIGH_CYCLES 10'h100
`define PWR_TOTAL_CYCLES 10'h200
`define RST_LOW_CYCLES 10'h008
`define COUNT_WIDTH 10

`endif

/* rtl/boot_pin_pkg.sv */
// Purpose: Types for the boot pin drive sequencer.
// Assumes: Nothing beyond the constants header.
// Notes: One pin drive record holds a drive mode for each shared pin.
package boot_pin_pkg;

   typedef enum logic [1:0]
   {
      DRIVE_RELEASE = 2'h0,
      DRIVE_STRONG_HIGH = 2'h1,
      DRIVE_RESISTIVE_LOW = 2'h2
   } drive_mode_t;

   typedef struct packed
   {
      drive_mode_t data_pin;
      drive_mode_t clock_pin;
   } pin_drive_t;

   typedef enum logic [3:0]
   {
      ST_POWER_UP = 4'h1,
      ST_RESET_HOLD = 4'h2,
      ST_RESET_LOW = 4'h4,
      ST_IDLE = 4'h8
   } seq_state_t;

endpackage

/* rtl/boot_pin_drive_sequencer.sv */
// Purpose: Drives the shared boot data and boot clock pins through their start-up states.
// Assumes: i_arst_n is power-on reset; i_sleep_tick pulses once per sleep-clock cycle.
// Assumes: i_external_reset_input is already a clean level, low when nothing drives it.
// Notes: o_*_oe high means the sequencer drives the pin; low hands it to the normal function.
// Notes: Both pins may disturb a shared serial bus while a drive interval runs.
// Notes: Interval lengths live in the constants header, drive codes in the package.
`timescale 1ns/10ps
`include "boot_pin_cfg.svh"

module boot_pin_drive_sequencer
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_sleep_tick,
   input wire logic i_external_reset_input,
   output boot_pin_pkg::pin_drive_t o_drive,
   output logic o_boot_data_pin_out,
   output logic o_boot_data_pin_oe,
   output logic o_boot_clock_pin_out,
   output logic o_boot_clock_pin_oe,
   output logic o_sequencer_active,
   output logic o_device_reset
);

   // ==========================================================
   // Reset release
   // Two flops keep the sequencer from leaving reset on a metastable edge
   logic rst_meta;
   logic rst_sync;
   logic next_rst_meta;
   logic next_rst_sync;

   always_comb
   begin
      next_rst_meta = 1'b1;
      next_rst_sync = rst_meta;
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= next_rst_meta;
         rst_sync <= next_rst_sync;
      end
   end

   // ==========================================================
   // Sequence state
   boot_pin_pkg::seq_state_t state;
   boot_pin_pkg::seq_state_t next_state;
   logic [`COUNT_WIDTH-1:0] count;
   logic [`COUNT_WIDTH-1:0] next_count;
   boot_pin_pkg::pin_drive_t drive;
   boot_pin_pkg::pin_drive_t next_drive;

   // ==========================================================
   // Interval end points
   logic [`COUNT_WIDTH-1:0] count_inc;
   logic power_up_done;
   logic reset_low_done;

   assign count_inc = count + `COUNT_WIDTH'(1);
   // Compared on the incremented value so release lands on the edge taking the last tick
   assign power_up_done = (count_inc == `PWR_TOTAL_CYCLES);
   assign reset_low_done = (count_inc == `RST_LOW_CYCLES);

   // A rising external reset aborts any interval from any state; the pins are
   // released while it is held so the device sits quietly in reset.
   // Ticks are counted only in the two drive states and ignored elsewhere.
   always_comb
   begin
      next_state = state;
      next_count = count;
      next_drive = drive;
      unique case (state)
         boot_pin_pkg::ST_POWER_UP:
         begin
            if (i_external_reset_input)
            begin
               next_state = boot_pin_pkg::ST_RESET_HOLD;
               next_count = '0;
            end
            else if (i_sleep_tick)
            begin
               next_count = count_inc;
               if (power_up_done)
               begin
                  next_state = boot_pin_pkg::ST_IDLE;
               end
            end
            // The drive follows the count about to be held, so it changes with the tick
            if (next_state == boot_pin_pkg::ST_POWER_UP)
            begin
               next_drive.data_pin = (next_count < `PWR_HIGH_CYCLES) ?
                  boot_pin_pkg::DRIVE_STRONG_HIGH : boot_pin_pkg::DRIVE_RESISTIVE_LOW;
               next_drive.clock_pin = boot_pin_pkg::DRIVE_RESISTIVE_LOW;
            end
            else
            begin
               next_drive.data_pin = boot_pin_pkg::DRIVE_RELEASE;
               next_drive.clock_pin = boot_pin_pkg::DRIVE_RELEASE;
            end
         end

         boot_pin_pkg::ST_RESET_HOLD:
         begin
            next_drive.data_pin = boot_pin_pkg::DRIVE_RELEASE;
            next_drive.clock_pin = boot_pin_pkg::DRIVE_RELEASE;
            if (!i_external_reset_input)
            begin
               // Counting restarts from zero on the falling reset
               next_state = boot_pin_pkg::ST_RESET_LOW;
               next_count = '0;
               next_drive.data_pin = boot_pin_pkg::DRIVE_RESISTIVE_LOW;
               next_drive.clock_pin = boot_pin_pkg::DRIVE_RESISTIVE_LOW;
            end
         end

         boot_pin_pkg::ST_RESET_LOW:
         begin
            if (i_external_reset_input)
            begin
               // A reset rising again mid-interval returns to the hold
               next_state = boot_pin_pkg::ST_RESET_HOLD;
               next_drive.data_pin = boot_pin_pkg::DRIVE_RELEASE;
               next_drive.clock_pin = boot_pin_pkg::DRIVE_RELEASE;
            end
            else if (i_sleep_tick)
            begin
               next_count = count_inc;
               if (reset_low_done)
               begin
                  next_state = boot_pin_pkg::ST_IDLE;
                  next_drive.data_pin = boot_pin_pkg::DRIVE_RELEASE;
                  next_drive.clock_pin = boot_pin_pkg::DRIVE_RELEASE;
               end
            end
         end

         boot_pin_pkg::ST_IDLE:
         begin
            // Idle ignores ticks; only a new reset restarts the drive intervals
            next_drive.data_pin = boot_pin_pkg::DRIVE_RELEASE;
            next_drive.clock_pin = boot_pin_pkg::DRIVE_RELEASE;
            if (i_external_reset_input)
            begin
               next_state = boot_pin_pkg::ST_RESET_HOLD;
               next_count = '0;
            end
         end

         default:
         begin
            next_state = boot_pin_pkg::ST_IDLE;
            next_count = '0;
            next_drive.data_pin = boot_pin_pkg::DRIVE_RELEASE;
            next_drive.clock_pin = boot_pin_pkg::DRIVE_RELEASE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         state <= boot_pin_pkg::ST_POWER_UP;
         count <= '0;
         // Data strong high and clock low start together at power-up
         drive <= '{boot_pin_pkg::DRIVE_STRONG_HIGH, boot_pin_pkg::DRIVE_RESISTIVE_LOW};
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         drive <= next_drive;
      end
   end

   // ==========================================================
   // Pin drive outputs
   // Entry 0 is the boot data pin, entry 1 the boot clock pin
   boot_pin_pkg::drive_mode_t pin_mode [2];
   logic [1:0] pin_out;
   logic [1:0] pin_oe;

   assign pin_mode[0] = drive.data_pin;
   assign pin_mode[1] = drive.clock_pin;

   generate
      for (genvar pin = 0; pin < 2; pin++)
      begin : g_pin
         boot_pin_pkg::drive_mode_t mode;

         assign mode = pin_mode[pin];
         // Only strong high drives a one; resistive low is a weak zero whose strength o_drive carries
         assign pin_out[pin] = (mode == boot_pin_pkg::DRIVE_STRONG_HIGH);
         // Release hands the pin back to its normal function
         assign pin_oe[pin] = (mode != boot_pin_pkg::DRIVE_RELEASE);
      end
   endgenerate

   assign o_drive = drive;
   assign o_boot_data_pin_out = pin_out[0];
   assign o_boot_data_pin_oe = pin_oe[0];
   assign o_boot_clock_pin_out = pin_out[1];
   assign o_boot_clock_pin_oe = pin_oe[1];

   // ==========================================================
   // Status outputs
   // Active stays high through every drive interval and the reset hold
   assign o_sequencer_active = (state != boot_pin_pkg::ST_IDLE);
   assign o_device_reset = (state == boot_pin_pkg::ST_RESET_HOLD);

endmodule

/* test/boot_pin_monitor.sv */
// Purpose: Port checker. Assumes: bound to the sequencer. Notes: one clock domain.
`timescale 1ns/10ps
module boot_pin_monitor
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_sleep_tick,
   input wire logic i_external_reset_input,
   input boot_pin_pkg::pin_drive_t o_drive,
   input wire logic o_boot_data_pin_oe,
   input wire logic o_sequencer_active,
   input wire logic o_device_reset
);
   localparam boot_pin_pkg::drive_mode_t SH = boot_pin_pkg::DRIVE_STRONG_HIGH;
   localparam boot_pin_pkg::drive_mode_t RL = boot_pin_pkg::DRIVE_RESISTIVE_LOW;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   property p_hold; o_drive.data_pin == SH && !i_sleep_tick && !i_external_reset_input |=> o_drive.data_pin == SH; endproperty
   a_hold: assert property (p_hold) else $error("data left strong high without tick");
   property p_low; $past(o_drive.data_pin) == SH && o_drive.data_pin == RL |-> $past(i_sleep_tick); endproperty
   a_low: assert property (p_low) else $error("data went low without tick");
   property p_clk; o_drive.data_pin == SH |-> o_drive.clock_pin == RL; endproperty
   a_clk: assert property (p_clk) else $error("clock pin not low with data high");
   property p_rel; !o_sequencer_active |-> o_drive == '0 && !o_boot_data_pin_oe; endproperty
   a_rel: assert property (p_rel) else $error("pins driven while idle");
   property p_ext; $fell(i_external_reset_input) |=> o_drive == {RL, RL}; endproperty
   a_ext: assert property (p_ext) else $error("pins not low after reset fall");
   property p_rst; i_external_reset_input |=> o_device_reset && o_drive == '0; endproperty
   a_rst: assert property (p_rst) else $error("reset not applied");
   property p_idle; !o_sequencer_active && !i_external_reset_input |=> !o_sequencer_active; endproperty
   a_idle: assert property (p_idle) else $error("idle left without reset");
endmodule
bind boot_pin_drive_sequencer boot_pin_monitor u_mon (.*);

/* test/boot_bus_model.sv */
// Purpose: Far side with bus pull-ups. Assumes: none. Notes: reset source floats low.
`timescale 1ns/10ps
module boot_bus_model
(
   input wire logic i_data_out,
   input wire logic i_data_oe,
   input wire logic i_clock_out,
   input wire logic i_clock_oe,
   input wire logic i_reset_en,
   output logic o_sda,
   output logic o_scl,
   output logic o_external_reset
);
   assign o_sda = i_data_oe ? i_data_out : 1'b1;
   assign o_scl = i_clock_oe ? i_clock_out : 1'b1;
   assign o_external_reset = i_reset_en;
endmodule

/* test/boot_pin_drive_sequencer_tb.sv */
// Purpose: Sequencer bench. Assumes: ticks at negedge. Notes: none.
`timescale 1ns/10ps
module boot_pin_drive_sequencer_tb;
   localparam boot_pin_pkg::drive_mode_t SH = boot_pin_pkg::DRIVE_STRONG_HIGH;
   localparam boot_pin_pkg::drive_mode_t RL = boot_pin_pkg::DRIVE_RESISTIVE_LOW;
   localparam boot_pin_pkg::drive_mode_t RE = boot_pin_pkg::DRIVE_RELEASE;
   logic i_clock = 0, i_arst_n = 0, i_sleep_tick = 0, rst_en = 0;
   logic d_out, d_oe, c_out, c_oe, act, dev, ext, sda, scl;
   boot_pin_pkg::pin_drive_t drv;
   int err_total = 0, samples_checked = 0;
   boot_pin_drive_sequencer dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sleep_tick(i_sleep_tick),
      .i_external_reset_input(ext), .o_drive(drv), .o_boot_data_pin_out(d_out), .o_boot_data_pin_oe(d_oe),
      .o_boot_clock_pin_out(c_out), .o_boot_clock_pin_oe(c_oe), .o_sequencer_active(act), .o_device_reset(dev));
   boot_bus_model bus (.i_data_out(d_out), .i_data_oe(d_oe), .i_clock_out(c_out), .i_clock_oe(c_oe),
      .i_reset_en(rst_en), .o_sda(sda), .o_scl(scl), .o_external_reset(ext));
   task automatic final_report();
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic look(string what, boot_pin_pkg::drive_mode_t d, boot_pin_pkg::drive_mode_t c, logic a, logic r);
      samples_checked++;
      if ({drv, act, dev, sda, scl} !== {d, c, a, r, d != RL, c != RL})
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, {d, c, a, r, d != RL, c != RL}, {drv, act, dev, sda, scl});
      end
   endtask
   task automatic tk(int n);
      repeat (n)
      begin
         @(negedge i_clock) i_sleep_tick = 1;
         @(negedge i_clock) i_sleep_tick = 0;
      end
   endtask
   task automatic do_reset();
      @(negedge i_clock) i_arst_n = 0;
      repeat (8) @(negedge i_clock);
      i_arst_n = 1;
      repeat (4) @(negedge i_clock);
   endtask
   task automatic power_up();
      look("start", SH, RL, 1, 0);
      tk(255);
      look("tick 255", SH, RL, 1, 0);
      tk(1);
      look("tick 256", RL, RL, 1, 0);
      tk(255);
      look("tick 511", RL, RL, 1, 0);
      tk(1);
      look("tick 512", RE, RE, 0, 0);
      tk(20);
      look("idle", RE, RE, 0, 0);
   endtask
   task automatic ext_reset();
      @(negedge i_clock) rst_en = 1;
      tk(3);
      look("ext held", RE, RE, 1, 1);
      @(negedge i_clock) rst_en = 0;
      @(negedge i_clock);
      look("ext fell", RL, RL, 1, 0);
      tk(7);
      look("ext 7", RL, RL, 1, 0);
      tk(1);
      look("ext 8", RE, RE, 0, 0);
      tk(9);
      look("ext idle", RE, RE, 0, 0);
   endtask
   task automatic ext_abort();
      @(negedge i_clock) rst_en = 1;
      @(negedge i_clock) rst_en = 0;
      tk(4);
      look("low 4", RL, RL, 1, 0);
      @(negedge i_clock) rst_en = 1;
      @(negedge i_clock);
      look("low abort", RE, RE, 1, 1);
      @(negedge i_clock) rst_en = 0;
      tk(8);
      look("abort done", RE, RE, 0, 0);
   endtask
   initial
   begin
      forever #4 i_clock = ~i_clock;
   end
   initial
   begin
      #60000;
      err_total++;
      final_report();
   end
   initial
   begin
      do_reset();
      power_up();
      ext_reset();
      do_reset();
      tk(100);
      ext_reset();
      ext_abort();
      final_report();
   end
endmodule
